// ---- logic/bcc_map.vh ----
// bcc_map.vh: constants for the block check calculator
// assumes inclusion by bare name from the calculator and the verif files
`ifndef BCC_MAP_VH
`define BCC_MAP_VH

// =====================================================
// formula select codes
`define BCC_MODE_SUM      2'h0
`define BCC_MODE_LRC      2'h1
`define BCC_MODE_CRC      2'h2

// =====================================================
// crc constants
`define BCC_CRC_PRESET    16'hFFFF
`define BCC_CRC_POLY      16'hA001
`define BCC_CRC_SHIFTS    4'h8

// =====================================================
// digit counts for the summing formula
`define BCC_DIGITS_W      3
`define BCC_ASCII_DIGITS  3'h2

`endif

// ---- logic/bcc_hex_ascii.v ----
// bcc_hex_ascii.v: one nibble to one ascii hex character and back
// emits upper-case digits, decodes either case; invalid characters decode as zero
`timescale 1ns/10ps
`default_nettype none

module bcc_hex_ascii (
    input  wire [3:0] nib_in,
    input  wire [7:0] chr_in,
    output wire [7:0] chr_out,
    output reg  [3:0] nib_out
);

    assign chr_out = (nib_in < 4'hA) ? (8'h30 + {4'h0, nib_in}) : (8'h37 + {4'h0, nib_in});

    always @* begin
        if (chr_in >= 8'h30 && chr_in <= 8'h39) begin
            nib_out = chr_in[3:0];
        end else if ((chr_in >= 8'h41 && chr_in <= 8'h46) ||
                     (chr_in >= 8'h61 && chr_in <= 8'h66)) begin
            nib_out = chr_in[3:0] + 4'h9;
        end else begin
            nib_out = 4'h0;
        end
    end

endmodule
`default_nettype wire

// ---- logic/bcc_calc.v ----
// bcc_calc.v: block check character over a byte stream
// assumes framing logic presents the range bytes one per valid cycle
// Summary of operation
// [R1] three selectable formulas for send and receive
// [R2] sum range bytes, invert, add one
// [R3] sum result raw or ascii, given digits
// [R4] ascii two digits: low byte, high nibble first
// [R5] lrc: char pairs decode to one byte
// [R6] lrc: negate sum, emit two ascii chars
// [R7] lrc range must be even length
// [R8] crc preset all ones, xor first byte
// [R9] eight right shifts, xor poly on carry
// [R10] xor next byte, repeat to range end
// [R11] crc stored low byte first
// [R12] carry is lsb before the shift
`timescale 1ns/10ps
`default_nettype none
`include "bcc_map.vh"

module bcc_calc (
    input  wire                    clk_in,
    input  wire                    srst_in,
    input  wire                    start_in,
    input  wire [1:0]              mode_in,
    input  wire                    ascii_in,
    input  wire [`BCC_DIGITS_W-1:0] digits_in,
    input  wire                    byte_valid_in,
    input  wire [7:0]              byte_in,
    output wire                    byte_ready_out,
    input  wire                    last_in,
    output reg                     done_out,
    output reg  [15:0]             result_out,
    output reg  [7:0]              check_0_out,
    output reg  [7:0]              check_1_out,
    output reg  [7:0]              check_2_out,
    output reg  [7:0]              check_3_out,
    output reg  [2:0]              check_len_out
);

    // =====================================================
    // state
    localparam ST_IDLE  = 2'h0;
    localparam ST_RUN   = 2'h1;
    localparam ST_SHIFT = 2'h2;
    localparam ST_FIN   = 2'h3;

    reg [1:0]  state;
    reg [1:0]  mode;
    reg        ascii;
    reg [2:0]  digits;
    reg [15:0] acc;
    reg        first;
    reg        lrc_half;
    reg [3:0]  lrc_hi;
    reg [3:0]  shift_cnt;
    reg        last_seen;

    assign byte_ready_out = (state == ST_RUN);

    // =====================================================
    // hex conversion, one instance per nibble
    wire [3:0]  dec_nib;
    wire [7:0]  chr0;
    wire [7:0]  chr1;
    wire [7:0]  chr2;
    wire [7:0]  chr3;
    wire [15:0] neg_acc = (~acc) + 16'h0001; // [R2] [R6]

    bcc_hex_ascii u_dec (
        .nib_in  (4'h0),
        .chr_in  (byte_in),
        .chr_out (),
        .nib_out (dec_nib)
    );
    bcc_hex_ascii u_h0 (
        .nib_in  (neg_acc[3:0]),
        .chr_in  (8'h00),
        .chr_out (chr0),
        .nib_out ()
    );
    bcc_hex_ascii u_h1 (
        .nib_in  (neg_acc[7:4]),
        .chr_in  (8'h00),
        .chr_out (chr1),
        .nib_out ()
    );
    bcc_hex_ascii u_h2 (
        .nib_in  (neg_acc[11:8]),
        .chr_in  (8'h00),
        .chr_out (chr2),
        .nib_out ()
    );
    bcc_hex_ascii u_h3 (
        .nib_in  (neg_acc[15:12]),
        .chr_in  (8'h00),
        .chr_out (chr3),
        .nib_out ()
    );

    // =====================================================
    // one crc step; carry taken before shifting
    wire [15:0] crc_shr  = {1'b0, acc[15:1]};
    wire [15:0] crc_step = acc[0] ? (crc_shr ^ `BCC_CRC_POLY) : crc_shr; // [R9] [R12]

    wire take = byte_valid_in && (state == ST_RUN);

    always @(posedge clk_in) begin
        if (srst_in) begin
            state         <= ST_IDLE;
            mode          <= `BCC_MODE_SUM;
            ascii         <= 1'b0;
            digits        <= 3'h0;
            acc           <= 16'h0000;
            first         <= 1'b0;
            lrc_half      <= 1'b0;
            lrc_hi        <= 4'h0;
            shift_cnt     <= 4'h0;
            last_seen     <= 1'b0;
            done_out      <= 1'b0;
            result_out    <= 16'h0000;
            check_0_out   <= 8'h00;
            check_1_out   <= 8'h00;
            check_2_out   <= 8'h00;
            check_3_out   <= 8'h00;
            check_len_out <= 3'h0;
        end else begin
            done_out <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start_in) begin
                        mode      <= mode_in; // [R1]
                        ascii     <= ascii_in;
                        digits    <= digits_in;
                        acc       <= 16'h0000;
                        first     <= 1'b1;
                        lrc_half  <= 1'b0;
                        last_seen <= 1'b0;
                        state     <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (take) begin
                        first     <= 1'b0;
                        last_seen <= last_in;
                        case (mode)
                            `BCC_MODE_CRC: begin
                                // first byte meets the all-ones preset
                                acc       <= (first ? `BCC_CRC_PRESET : acc) ^ {8'h00, byte_in}; // [R8] [R10]
                                shift_cnt <= 4'h0;
                                state     <= ST_SHIFT;
                            end
                            `BCC_MODE_LRC: begin
                                // odd range leaves a dangling high nibble
                                if (lrc_half) begin
                                    acc <= acc + {8'h00, lrc_hi, dec_nib}; // [R5] [R7]
                                end else begin
                                    lrc_hi <= dec_nib;
                                end
                                lrc_half <= ~lrc_half;
                                if (last_in) begin
                                    state <= ST_FIN;
                                end
                            end
                            default: begin
                                acc <= acc + {8'h00, byte_in}; // [R2]
                                if (last_in) begin
                                    state <= ST_FIN;
                                end
                            end
                        endcase
                    end
                end
                ST_SHIFT: begin
                    acc       <= crc_step; // [R9]
                    shift_cnt <= shift_cnt + 4'h1;
                    if (shift_cnt == `BCC_CRC_SHIFTS - 4'h1) begin
                        state <= last_seen ? ST_FIN : ST_RUN; // [R10]
                    end
                end
                ST_FIN: begin
                    done_out <= 1'b1;
                    state    <= ST_IDLE;
                    case (mode)
                        `BCC_MODE_CRC: begin
                            result_out    <= acc;
                            check_0_out   <= acc[7:0]; // [R11]
                            check_1_out   <= acc[15:8];
                            check_2_out   <= 8'h00;
                            check_3_out   <= 8'h00;
                            check_len_out <= 3'h2;
                        end
                        `BCC_MODE_LRC: begin
                            result_out    <= {8'h00, neg_acc[7:0]};
                            check_0_out   <= chr1; // [R6]
                            check_1_out   <= chr0;
                            check_2_out   <= 8'h00;
                            check_3_out   <= 8'h00;
                            check_len_out <= 3'h2;
                        end
                        default: begin
                            result_out <= neg_acc;
                            if (ascii) begin
                                // digits beyond four clip to four
                                check_len_out <= (digits > 3'h4) ? 3'h4 : digits; // [R3]
                                case (digits)
                                    3'h1: begin
                                        check_0_out <= chr0;
                                        check_1_out <= 8'h00;
                                        check_2_out <= 8'h00;
                                        check_3_out <= 8'h00;
                                    end
                                    `BCC_ASCII_DIGITS: begin
                                        check_0_out <= chr1; // [R4]
                                        check_1_out <= chr0;
                                        check_2_out <= 8'h00;
                                        check_3_out <= 8'h00;
                                    end
                                    3'h3: begin
                                        check_0_out <= chr2;
                                        check_1_out <= chr1;
                                        check_2_out <= chr0;
                                        check_3_out <= 8'h00;
                                    end
                                    default: begin
                                        check_0_out <= chr3;
                                        check_1_out <= chr2;
                                        check_2_out <= chr1;
                                        check_3_out <= chr0;
                                    end
                                endcase
                            end else begin
                                check_len_out <= (digits > 3'h2) ? 3'h2 : digits; // [R3]
                                if (digits >= 3'h2) begin
                                    check_0_out <= neg_acc[15:8];
                                    check_1_out <= neg_acc[7:0];
                                end else begin
                                    check_0_out <= neg_acc[7:0];
                                    check_1_out <= 8'h00;
                                end
                                check_2_out <= 8'h00;
                                check_3_out <= 8'h00;
                            end
                        end
                    endcase
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ---- verif/bcc_calc_assertions.sv ----
// bcc_calc_assertions.sv: timing and format checks on the calculator ports
// assumes the bench holds mode, ascii and digits steady through each run
`timescale 1ns/10ps
`default_nettype none
`include "bcc_map.vh"
// ==========================================
// checker
module bcc_calc_assertions (
    input wire logic                      clk_in,
    input wire logic                      srst_in,
    input wire logic                      start_in,
    input wire logic [1:0]                mode_in,
    input wire logic                      ascii_in,
    input wire logic [`BCC_DIGITS_W-1:0]  digits_in,
    input wire logic                      byte_valid_in,
    input wire logic [7:0]                byte_in,
    input wire logic                      byte_ready_out,
    input wire logic                      last_in,
    input wire logic                      done_out,
    input wire logic [15:0]               result_out,
    input wire logic [7:0]                check_0_out,
    input wire logic [7:0]                check_1_out,
    input wire logic [7:0]                check_2_out,
    input wire logic [7:0]                check_3_out,
    input wire logic [2:0]                check_len_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    function automatic [7:0] hx(input [3:0] n);
        hx = (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
    endfunction
    wire take_last = byte_valid_in && byte_ready_out && last_in;
    wire crc_mode = (mode_in == 2'h2);
    a_done_pulse: assert property (done_out |=> !done_out) else $error("done held");
    a_reset_clear: assert property (disable iff (1'b0) srst_in |=>
        !done_out && !byte_ready_out && check_len_out == 3'h0) else $error("reset state");
    a_sum_time: assert property (take_last && !crc_mode |-> ##2 done_out)
        else $error("sum or lrc done late");
    a_crc_time: assert property (take_last && crc_mode |-> ##10 done_out)
        else $error("crc done late");
    a_crc_shifts: assert property (byte_valid_in && byte_ready_out && crc_mode
        |=> !byte_ready_out [*8]) else $error("crc took byte mid shift");
    a_crc_order: assert property (done_out && crc_mode |-> check_len_out == 3'h2 &&
        check_0_out == result_out[7:0] && check_1_out == result_out[15:8])
        else $error("crc byte order");
    a_lrc_chars: assert property (done_out && mode_in == 2'h1 |-> check_len_out == 3'h2 &&
        check_0_out == hx(result_out[7:4]) && check_1_out == hx(result_out[3:0]))
        else $error("lrc chars");
    a_sum_ascii: assert property (done_out && !mode_in[0] && !crc_mode && ascii_in &&
        digits_in == `BCC_ASCII_DIGITS |-> check_len_out == 3'h2 &&
        check_0_out == hx(result_out[7:4]) && check_1_out == hx(result_out[3:0]))
        else $error("sum ascii chars");
    c_sum: cover property (done_out && mode_in == 2'h0);
    c_lrc: cover property (done_out && mode_in == 2'h1);
    c_crc: cover property (done_out && crc_mode);
endmodule
bind bcc_calc bcc_calc_assertions chk_u (.clk_in(clk_in), .srst_in(srst_in),
    .start_in(start_in), .mode_in(mode_in), .ascii_in(ascii_in), .digits_in(digits_in),
    .byte_valid_in(byte_valid_in), .byte_in(byte_in), .byte_ready_out(byte_ready_out),
    .last_in(last_in), .done_out(done_out), .result_out(result_out),
    .check_0_out(check_0_out), .check_1_out(check_1_out), .check_2_out(check_2_out),
    .check_3_out(check_3_out), .check_len_out(check_len_out));
`default_nettype wire

// ---- verif/bcc_frame_model.sv ----
// bcc_frame_model.sv: framing side that feeds the checked range bytes
// assumes mem is loaded and go_in raised together with the start request
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// byte feeder
module bcc_frame_model (
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    input  wire logic       go_in,
    input  wire logic       stall_in,
    input  wire logic       ready_in,
    input  wire logic [4:0] len_in,
    output var  logic       valid_out,
    output var  logic       last_out,
    output var  logic [7:0] byte_out
);
    logic [7:0] mem [0:15];
    logic       act;
    logic [4:0] idx;
    wire  [4:0] n = idx + {4'h0, valid_out};
    always @(posedge clk_in) begin
        if (srst_in) begin
            act       <= 1'b0;
            valid_out <= 1'b0;
            last_out  <= 1'b0;
            byte_out  <= 8'hA5;
            idx       <= 5'h00;
        end else if (go_in) begin
            act <= 1'b1;
            idx <= 5'h00;
        end else if (act && (!valid_out || ready_in)) begin
            // released line flips so a stale byte never looks fresh
            if ((valid_out && last_out) || stall_in) begin
                valid_out <= 1'b0;
                byte_out  <= ~byte_out;
                act       <= !(valid_out && last_out);
            end else begin
                valid_out <= 1'b1;
                byte_out  <= mem[n[3:0]];
                last_out  <= (n == len_in - 5'h01);
            end
            idx <= n;
        end
    end
endmodule
`default_nettype wire

// ---- verif/test_block_check_calculator.sv ----
// test_block_check_calculator.sv: random and corner runs of all formulas
// assumes the frame model in the far-side role and the bound checker
`timescale 1ns/10ps
`default_nettype none
`include "bcc_map.vh"
// ==========================================
// bench
module test_block_check_calculator;
    logic                     clk_in = 1'b0;
    logic                     srst_in = 1'b1;
    logic                     start_in = 1'b0;
    logic [1:0]               mode_in = 2'h0;
    logic                     ascii_in = 1'b0;
    logic [`BCC_DIGITS_W-1:0] digits_in = 3'h0;
    logic [4:0]               n_bytes = 5'h01;
    logic                     stall = 1'b0;
    logic                     stall_en = 1'b0;
    logic                     valid, last, ready, done;
    logic [7:0]               byte_v, c0, c1, c2, c3;
    logic [15:0]              res;
    logic [2:0]               len;
    logic [31:0]              seed = 73869;
    logic [31:0]              sd2 = 73869;
    logic [7:0]               buf_q [0:15];
    int                       miscompares = 0;
    int                       n_tests = 0;
    int                       cyc = 0;
    always #5 clk_in = ~clk_in;
    bcc_calc dut_u (.clk_in(clk_in), .srst_in(srst_in), .start_in(start_in), .mode_in(mode_in),
        .ascii_in(ascii_in), .digits_in(digits_in), .byte_valid_in(valid), .byte_in(byte_v),
        .byte_ready_out(ready), .last_in(last), .done_out(done), .result_out(res),
        .check_0_out(c0), .check_1_out(c1), .check_2_out(c2), .check_3_out(c3),
        .check_len_out(len));
    bcc_frame_model frm_u (.clk_in(clk_in), .srst_in(srst_in), .go_in(start_in),
        .stall_in(stall), .ready_in(ready), .len_in(n_bytes), .valid_out(valid),
        .last_out(last), .byte_out(byte_v));
    function automatic [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic [7:0] hx(input [3:0] n);
        hx = (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
    endfunction
    function automatic [3:0] nb(input [7:0] c);
        nb = (c < 8'h41) ? c[3:0] : c[3:0] + 4'h9;
    endfunction
    function automatic [15:0] calc(input [1:0] m, input int n);
        logic [15:0] a;
        a = (m == 2'h2) ? 16'hFFFF : 16'h0000;
        for (int i = 0; i < n; i++) begin
            if (m == 2'h2) begin
                a = a ^ buf_q[i];
                for (int k = 0; k < 8; k++) a = a[0] ? (a >> 1) ^ 16'hA001 : a >> 1;
            end else if (m == 2'h1) begin
                if (i[0]) a = a + {nb(buf_q[i - 1]), nb(buf_q[i])};
            end else a = a + buf_q[i];
        end
        calc = (m == 2'h2) ? a : (m == 2'h1) ? {8'h00, ~a[7:0] + 8'h01} : ~a + 16'h0001;
    endfunction
    task automatic final_report;
        if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input [15:0] exp, input [15:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic run(input [1:0] m, input a, input [2:0] d, input int n, input rnd);
        logic [15:0] e;
        logic [7:0]  ex [0:3];
        logic [2:0]  el;
        int          t;
        for (int i = 0; i < n && rnd; i++) begin
            seed = lfsr(seed);
            buf_q[i] = (m == 2'h1) ? hx(seed[3:0]) : seed[7:0];
        end
        frm_u.mem = buf_q;
        e = calc(m, n);
        @(posedge clk_in);
        mode_in <= m;
        ascii_in <= a;
        digits_in <= d;
        n_bytes <= n[4:0];
        start_in <= 1'b1;
        @(posedge clk_in);
        start_in <= 1'b0;
        t = 0;
        while (done !== 1'b1 && t < 400) begin
            @(posedge clk_in);
            #1;
            t++;
        end
        el = (m == 2'h1 || m == 2'h2 || (!a && d > 3'h2)) ? 3'h2 : (d > 3'h4) ? 3'h4 : d;
        for (int k = 0; k < 4; k++) ex[k] = (k >= el) ? 8'h00 :
            (m == 2'h1) ? hx(e[7 - 4 * k -: 4]) : (m == 2'h2) ? e[8 * k +: 8] :
            a ? hx(e >> (4 * (el - 1 - k))) : e >> (8 * (el - 1 - k));
        chk("done", 16'h0001, {15'h0, done});
        chk("result", e, res);
        chk("len", {13'h0, el}, {13'h0, len});
        chk("check 0", {8'h00, ex[0]}, {8'h00, c0});
        chk("check 1", {8'h00, ex[1]}, {8'h00, c1});
        chk("check 2", {8'h00, ex[2]}, {8'h00, c2});
        chk("check 3", {8'h00, ex[3]}, {8'h00, c3});
        repeat (2) @(posedge clk_in);
    endtask
    always @(posedge clk_in) begin
        sd2 <= lfsr(sd2);
        stall <= stall_en & sd2[0];
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        buf_q[0] = 8'h8B;
        run(2'h0, 1'b1, 3'h2, 1, 1'b0);
        run(2'h0, 1'b0, 3'h1, 1, 1'b0);
        buf_q[0] = 8'h37;
        buf_q[1] = 8'h35;
        run(2'h1, 1'b0, 3'h2, 2, 1'b0);
        for (int i = 0; i < 30; i++) begin
            seed = lfsr(seed);
            stall_en <= seed[16];
            if (seed[9:8] == 2'h1) run(2'h1, 1'b0, 3'h2, 2 * (1 + seed[14:12]), 1'b1);
            else run(seed[9:8], seed[10], seed[10] ? 3'h1 + seed[12:11] : 3'h2, 1 + seed[15:12], 1'b1);
        end
        @(posedge clk_in);
        mode_in <= 2'h2;
        start_in <= 1'b1;
        @(posedge clk_in);
        start_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        srst_in <= 1'b1;
        @(posedge clk_in);
        srst_in <= 1'b0;
        #1;
        chk("len after reset", 16'h0000, {13'h0, len});
        run(2'h2, 1'b0, 3'h2, 16, 1'b1);
        final_report();
    end
endmodule
`default_nettype wire
